// file: logic/sfc_frontend.v
// device-side serial command front end of a quad-capable serial flash
// Function
// - invalid instruction: standby until chip select rises
// - standby keeps data output pin high-impedance
// - valid instruction: active until chip select rises, except an array access while write busy
// - sample on rising edge, launch on falling
// - mode 0 and 3 accepted without configuration
// - read-type: data out, stop at any bit
// - write-type must end on byte boundary
// - array access ignored while write busy
// - enter opcode selects four-line protocol, quad-enable untouched
// - exit opcode returns to single-line protocol
// - quad protocol uses four lines for all phases
`timescale 1ns/1ps
`include "sfc_map.vh"
module sfc_frontend (
  input  wire       CLK,
  input  wire       RESETN,
  input  wire       CS_N,
  input  wire       SCLK,
  input  wire [3:0] SIO_IN,
  output reg  [3:0] SIO_OUT,
  output reg  [3:0] SIO_OE_N,
  input  wire       BUSY,
  output reg        OP_VALID,
  output reg  [7:0] OP_CODE,
  input  wire [1:0] OP_CLASS,
  input  wire       OP_ARRAY,
  input  wire [2:0] HDR_BYTES,
  output reg        RX_VALID,
  output reg  [7:0] RX_BYTE,
  output reg        TX_REQ,
  input  wire [7:0] TX_DATA,
  output reg        EXEC,
  output reg        DISCARD,
  output reg        ACTIVE,
  output reg        QUAD_MODE
);
  reg  [1:0] rst_pipe;
  wire       rst_n;
  wire       cs_n_s;
  wire       sclk_s;
  wire [3:0] sio_s;
  reg        cs_q;
  reg        sclk_q;
  reg  [2:0] state;
  reg  [2:0] bit_cnt;
  reg  [7:0] shift;
  reg  [7:0] tx_shift;
  reg  [2:0] hdr_left;
  wire       rise;
  wire       fall;
  wire [2:0] step;
  wire [7:0] next_shift;
  wire [2:0] next_cnt;
  wire       byte_done;

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // the link clock is slow enough to be oversampled; its edges are found here
  sfc_sync #(.WIDTH(6), .INIT(6'h20)) u_sync (
    .clk  (CLK),
    .rst_n(rst_n),
    .din  ({CS_N, SCLK, SIO_IN}),
    .dout ({cs_n_s, sclk_s, sio_s})
  );

  // edges are taken from the level history, so the idle level never matters
  assign rise       = sclk_s & ~sclk_q;
  assign fall       = ~sclk_s & sclk_q;
  assign step       = QUAD_MODE ? `SFC_STEP_QUAD : `SFC_STEP_SINGLE;
  assign next_shift = QUAD_MODE ? {shift[3:0], sio_s} : {shift[6:0], sio_s[`SFC_SI_BIT]};
  assign next_cnt   = bit_cnt + step;
  assign byte_done  = (next_cnt == 3'h0);

  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      cs_q      <= 1'b1;
      sclk_q    <= 1'b0;
      state     <= `SFC_ST_IDLE;
      bit_cnt   <= 3'h0;
      shift     <= 8'h00;
      tx_shift  <= 8'h00;
      hdr_left  <= 3'h0;
      SIO_OUT   <= 4'h0;
      SIO_OE_N  <= `SFC_OE_NONE;
      OP_VALID  <= 1'b0;
      OP_CODE   <= 8'h00;
      RX_VALID  <= 1'b0;
      RX_BYTE   <= 8'h00;
      TX_REQ    <= 1'b0;
      EXEC      <= 1'b0;
      DISCARD   <= 1'b0;
      ACTIVE    <= 1'b0;
      QUAD_MODE <= 1'b0;
    end else begin
      cs_q     <= cs_n_s;
      sclk_q   <= sclk_s;
      OP_VALID <= 1'b0;
      RX_VALID <= 1'b0;
      TX_REQ   <= 1'b0;
      EXEC     <= 1'b0;
      DISCARD  <= 1'b0;
      // user answers a request in the cycle it is shown
      if (TX_REQ) begin
        tx_shift <= TX_DATA;
      end
      if (cs_n_s) begin
        // deselect ends every phase, even mid byte of a data-out phase
        state    <= `SFC_ST_IDLE;
        ACTIVE   <= 1'b0;
        SIO_OE_N <= `SFC_OE_NONE;
        if (!cs_q && state == `SFC_ST_WIN) begin
          if (bit_cnt == 3'h0) begin
            EXEC <= 1'b1;
            // the quad-enable bit lives elsewhere and is never touched here
            if (OP_CODE == `SFC_OPC_QUAD_ENTER) begin
              QUAD_MODE <= 1'b1;
            end else if (OP_CODE == `SFC_OPC_QUAD_EXIT) begin
              QUAD_MODE <= 1'b0;
            end
          end else begin
            DISCARD <= 1'b1;
          end
        end
      end else begin
        case (state)
          `SFC_ST_IDLE: begin
            state   <= `SFC_ST_OPC;
            bit_cnt <= 3'h0;
            shift   <= 8'h00;
          end
          `SFC_ST_OPC: begin
            if (rise) begin
              shift   <= next_shift;
              bit_cnt <= next_cnt;
              if (byte_done) begin
                OP_CODE  <= next_shift;
                OP_VALID <= 1'b1;
                state    <= `SFC_ST_DEC;
              end
            end
          end
          `SFC_ST_DEC: begin
            if (OP_CODE == `SFC_OPC_QUAD_ENTER || OP_CODE == `SFC_OPC_QUAD_EXIT) begin
              state  <= `SFC_ST_WIN;
              ACTIVE <= 1'b1;
            end else if (OP_CLASS == `SFC_CLASS_INVALID) begin
              state <= `SFC_ST_STBY;
            end else if (OP_ARRAY && BUSY) begin
              // ignoring the access keeps the running operation undisturbed
              state <= `SFC_ST_STBY;
            end else if (OP_CLASS == `SFC_CLASS_READ) begin
              ACTIVE   <= 1'b1;
              hdr_left <= HDR_BYTES;
              if (HDR_BYTES == 3'h0) begin
                state    <= `SFC_ST_DOUT;
                TX_REQ   <= 1'b1;
                SIO_OE_N <= QUAD_MODE ? `SFC_OE_QUAD : `SFC_OE_SINGLE;
              end else begin
                state <= `SFC_ST_HDR;
              end
            end else if (OP_CLASS == `SFC_CLASS_WRITE) begin
              state  <= `SFC_ST_WIN;
              ACTIVE <= 1'b1;
            end else begin
              state <= `SFC_ST_STBY;
            end
          end
          `SFC_ST_HDR: begin
            if (rise) begin
              shift   <= next_shift;
              bit_cnt <= next_cnt;
              if (byte_done) begin
                RX_BYTE  <= next_shift;
                RX_VALID <= 1'b1;
                hdr_left <= hdr_left - 3'h1;
                if (hdr_left == 3'h1) begin
                  state    <= `SFC_ST_DOUT;
                  TX_REQ   <= 1'b1;
                  SIO_OE_N <= QUAD_MODE ? `SFC_OE_QUAD : `SFC_OE_SINGLE;
                end
              end
            end
          end
          `SFC_ST_DOUT: begin
            if (fall) begin
              bit_cnt <= next_cnt;
              if (QUAD_MODE) begin
                SIO_OUT  <= tx_shift[7:4];
                tx_shift <= {tx_shift[3:0], 4'h0};
              end else begin
                SIO_OUT  <= {2'h0, tx_shift[7], 1'b0};
                tx_shift <= {tx_shift[6:0], 1'b0};
              end
              if (byte_done) begin
                TX_REQ <= 1'b1;
              end
            end
          end
          `SFC_ST_WIN: begin
            if (rise) begin
              shift   <= next_shift;
              bit_cnt <= next_cnt;
              if (byte_done) begin
                RX_BYTE  <= next_shift;
                RX_VALID <= 1'b1;
              end
            end
          end
          `SFC_ST_STBY: begin
            SIO_OE_N <= `SFC_OE_NONE;
            ACTIVE   <= 1'b0;
          end
          default: begin
            state <= `SFC_ST_STBY;
          end
        endcase
      end
    end
  end
endmodule

// file: logic/sfc_map.vh
// constants of the serial flash command front end
`ifndef SFC_MAP_VH
`define SFC_MAP_VH

// protocol switch opcodes
`define SFC_OPC_QUAD_ENTER 8'h35
`define SFC_OPC_QUAD_EXIT  8'hF5

// instruction classes returned by user logic
`define SFC_CLASS_INVALID  2'h0
`define SFC_CLASS_READ     2'h1
`define SFC_CLASS_WRITE    2'h2

// front end states
`define SFC_ST_IDLE        3'h0
`define SFC_ST_OPC         3'h1
`define SFC_ST_DEC         3'h2
`define SFC_ST_HDR         3'h3
`define SFC_ST_DOUT        3'h4
`define SFC_ST_WIN         3'h5
`define SFC_ST_STBY        3'h6

// bits moved per clock edge and pin masks
`define SFC_STEP_SINGLE    3'h1
`define SFC_STEP_QUAD      3'h4
`define SFC_OE_NONE        4'hF
`define SFC_OE_SINGLE      4'hD
`define SFC_OE_QUAD        4'h0
`define SFC_SO_BIT         1
`define SFC_SI_BIT         0

`endif

// file: logic/sfc_sync.v
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module sfc_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] din,
  output reg  [WIDTH-1:0] dout
);
  reg [WIDTH-1:0] meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= INIT;
      dout <= INIT;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// file: dv/sfc_frontend_sva.sv
// port assertions for the serial command front end
`timescale 1ns/1ps
`include "sfc_map.vh"
module sfc_frontend_sva (
  input logic       CLK, RESETN, BUSY, OP_VALID, OP_ARRAY, TX_REQ, EXEC, DISCARD, ACTIVE, QUAD_MODE,
  input logic [1:0] OP_CLASS,
  input logic [2:0] HDR_BYTES,
  input logic [3:0] SIO_OE_N,
  input logic [7:0] OP_CODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // the user answer is taken while an ordinary opcode is announced; the switch pair ignores the class
  sequence s_ans;
    OP_VALID && OP_CODE != `SFC_OPC_QUAD_ENTER && OP_CODE != `SFC_OPC_QUAD_EXIT;
  endsequence
  sequence s_idle8;
    (SIO_OE_N == `SFC_OE_NONE && !ACTIVE && !TX_REQ)[*8];
  endsequence
  a_invalid_stby: assert property (
    s_ans ##0 OP_CLASS == `SFC_CLASS_INVALID |=> s_idle8) else $error("invalid opcode not refused");
  a_busy_ignore: assert property (
    s_ans ##0 BUSY && OP_ARRAY |=> s_idle8) else $error("array access taken while busy");
  a_read_start: assert property (
    s_ans ##0 OP_CLASS == `SFC_CLASS_READ && HDR_BYTES == 3'h0 && !(BUSY && OP_ARRAY) |=> TX_REQ ##1
    (ACTIVE && SIO_OE_N != `SFC_OE_NONE)) else $error("read data phase did not start");
  a_quad_enter: assert property (EXEC && OP_CODE == `SFC_OPC_QUAD_ENTER |-> QUAD_MODE)
    else $error("enter opcode left single-line protocol");
  a_quad_exit: assert property (EXEC && OP_CODE == `SFC_OPC_QUAD_EXIT |-> !QUAD_MODE)
    else $error("exit opcode left four-line protocol");
  a_mode_cause: assert property (!$stable(QUAD_MODE) |-> EXEC)
    else $error("protocol changed without a command");
  a_lines_match: assert property (
    SIO_OE_N != `SFC_OE_NONE |-> SIO_OE_N == (QUAD_MODE ? `SFC_OE_QUAD : `SFC_OE_SINGLE))
    else $error("driven lines do not match protocol");
  a_end_pulse: assert property (EXEC || DISCARD |-> !(EXEC && DISCARD) ##1 !(EXEC || DISCARD))
    else $error("end of command reported wrongly");
  a_opcode_once: assert property (OP_VALID |=> !OP_VALID[*8])
    else $error("opcode announced twice");
endmodule
bind sfc_frontend sfc_frontend_sva chk_u (.CLK(CLK), .RESETN(RESETN), .BUSY(BUSY), .OP_VALID(OP_VALID),
  .OP_ARRAY(OP_ARRAY), .TX_REQ(TX_REQ), .EXEC(EXEC), .DISCARD(DISCARD), .ACTIVE(ACTIVE),
  .QUAD_MODE(QUAD_MODE), .OP_CLASS(OP_CLASS), .HDR_BYTES(HDR_BYTES), .SIO_OE_N(SIO_OE_N), .OP_CODE(OP_CODE));

// file: dv/sfc_host.sv
// host serial controller model
`timescale 1ns/1ps
module sfc_host (
  input  logic       clk,
  input  logic [3:0] sio,
  output logic       cs_n, sclk, hen,
  output logic [3:0] hd
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    hen  = 1'b1;
    hd   = 4'hF;
  end
  // idle level picks mode 0 or 3; the clock stands still while deselected
  task start(input bit m3);
    sclk = m3;
    repeat (6) @(negedge clk);
    cs_n = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // each rising edge moves one bit or one nibble, most significant first
  task xfer(input logic [7:0] v, input int n, input bit q, input bit en, output logic [7:0] r);
    hen = en;
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      hd = q ? v[7:4] : {3'h7, v[7]};
      v = q ? v << 4 : v << 1;
      repeat (6) @(negedge clk);
      r = q ? {r[3:0], sio} : {r[6:0], sio[1]};
      sclk = 1'b1;
      repeat (6) @(negedge clk);
    end
  endtask
  task stop(input bit m3);
    if (!m3) sclk = 1'b0;
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    hen = 1'b1;
    repeat (24) @(negedge clk);
  endtask
endmodule

// file: dv/sfc_frontend_tb.sv
// self-checking bench for the serial command front end
`timescale 1ns/1ps
`include "sfc_map.vh"
module sfc_frontend_tb;
  logic        CLK, RESETN, BUSY, OP_ARRAY, OP_VALID, RX_VALID, TX_REQ, EXEC, DISCARD, ACTIVE, QUAD_MODE, CS_N, SCLK, hen;
  logic [1:0]  OP_CLASS;
  logic [2:0]  HDR_BYTES;
  logic [3:0]  SIO_OUT, SIO_OE_N, hd;
  logic [7:0]  OP_CODE, RX_BYTE, TX_DATA, r;
  wire  [3:0]  sio = (~SIO_OE_N & SIO_OUT) | (SIO_OE_N & (hen ? hd : ~hd));
  int          errors, tests_run, n_ex, n_ds, n_rx, cyc, e0, d0;
  // idle level, bits after opcode, opcode, data
  logic [23:0] rows [5] = '{24'h000600, 24'h100600, 24'h030600, 24'h1802C3, 24'h0502C3};
  sfc_host h_u (.clk(CLK), .sio(sio), .cs_n(CS_N), .sclk(SCLK), .hen(hen), .hd(hd));
  sfc_frontend dut_u (.CLK(CLK), .RESETN(RESETN), .CS_N(CS_N), .SCLK(SCLK), .SIO_IN(sio), .SIO_OUT(SIO_OUT),
    .SIO_OE_N(SIO_OE_N), .BUSY(BUSY), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE), .OP_CLASS(OP_CLASS),
    .OP_ARRAY(OP_ARRAY), .HDR_BYTES(HDR_BYTES), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE), .TX_REQ(TX_REQ),
    .TX_DATA(TX_DATA), .EXEC(EXEC), .DISCARD(DISCARD), .ACTIVE(ACTIVE), .QUAD_MODE(QUAD_MODE));
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  // user decode answers at the falling clock edge inside the cycle the opcode is announced
  always @(negedge CLK) begin
    OP_CLASS <= (OP_CODE == 8'h9F || OP_CODE == 8'h03 || OP_CODE == 8'h05) ? `SFC_CLASS_READ :
                (OP_CODE == 8'hFF) ? `SFC_CLASS_INVALID : `SFC_CLASS_WRITE;
    OP_ARRAY <= (OP_CODE == 8'h03 || OP_CODE == 8'h02);
    HDR_BYTES <= (OP_CODE == 8'h03) ? 3'h3 : 3'h0;
  end
  always @(posedge CLK) begin
    n_ex += (EXEC === 1'b1);
    n_ds += (DISCARD === 1'b1);
    n_rx += (RX_VALID === 1'b1);
    cyc++;
    if (cyc > 20000) begin
      errors++;
      wrap_up;
    end
  end
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task run(input bit m3, input bit q, input logic [7:0] op, input int nx, input logic [7:0] d);
    h_u.start(m3);
    h_u.xfer(op, q ? 2 : 8, q, 1'b1, r);
    h_u.xfer(d, nx, q, 1'b1, r);
    h_u.stop(m3);
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    RESETN = 1'b0;
    BUSY = 1'b0;
    TX_DATA = 8'h5A;
    repeat (8) @(negedge CLK);
    RESETN = 1'b1;
    repeat (5) @(negedge CLK);
    chk("oe_idle", 8'h0F, 8'(SIO_OE_N));
    foreach (rows[k]) begin
      e0 = n_ex;
      d0 = n_ds;
      run(rows[k][20], 1'b0, rows[k][15:8], rows[k][19:16], rows[k][7:0]);
      chk("exec", 8'(rows[k][18:16] == 3'h0), 8'(n_ex - e0));
      chk("discard", 8'(rows[k][18:16] != 3'h0), 8'(n_ds - d0));
      if (rows[k][19:16] == 4'h8) chk("rx_byte", rows[k][7:0], RX_BYTE);
    end
    h_u.start(1'b0);
    h_u.xfer(8'h9F, 8, 1'b0, 1'b1, r);
    h_u.xfer(8'h00, 8, 1'b0, 1'b1, r);
    chk("read_byte", 8'h5A, r);
    chk("active", 8'h01, 8'(ACTIVE));
    h_u.xfer(8'h00, 3, 1'b0, 1'b1, r);
    h_u.stop(1'b0);
    chk("active_end", 8'h00, 8'(ACTIVE));
    chk("oe_end", 8'h0F, 8'(SIO_OE_N));
    h_u.start(1'b1);
    h_u.xfer(8'hFF, 8, 1'b0, 1'b1, r);
    h_u.xfer(8'h00, 8, 1'b0, 1'b1, r);
    chk("oe_stby", 8'h0F, 8'(SIO_OE_N));
    chk("active_stby", 8'h00, 8'(ACTIVE));
    h_u.stop(1'b1);
    for (int b = 0; b < 2; b++) begin
      BUSY = (b == 0);
      e0 = n_rx;
      run(1'b0, 1'b0, 8'h03, 8, 8'h81);
      chk("hdr_bytes", 8'(b), 8'(n_rx - e0));
    end
    // the status byte tells the host that nothing is running
    TX_DATA = {7'h00, BUSY};
    run(1'b0, 1'b0, 8'h05, 8, 8'h00);
    chk("status_ready", 8'h00, r);
    run(1'b0, 1'b0, `SFC_OPC_QUAD_ENTER, 0, 8'h00);
    chk("quad_on", 8'h01, 8'(QUAD_MODE));
    TX_DATA = 8'hA5;
    h_u.start(1'b1);
    h_u.xfer(8'h9F, 2, 1'b1, 1'b1, r);
    h_u.xfer(8'h00, 2, 1'b1, 1'b0, r);
    h_u.stop(1'b1);
    chk("quad_read", 8'hA5, r);
    chk("opcode", 8'h9F, OP_CODE);
    run(1'b1, 1'b1, `SFC_OPC_QUAD_EXIT, 0, 8'h00);
    chk("quad_off", 8'h00, 8'(QUAD_MODE));
    // a reset in mid-run must also fall back to the single-line protocol
    run(1'b0, 1'b0, `SFC_OPC_QUAD_ENTER, 0, 8'h00);
    RESETN = 1'b0;
    repeat (2) @(negedge CLK);
    RESETN = 1'b1;
    repeat (5) @(negedge CLK);
    chk("quad_reset", 8'h00, 8'(QUAD_MODE));
    chk("oe_reset", 8'h0F, 8'(SIO_OE_N));
    e0 = n_ex;
    run(1'b0, 1'b0, 8'h06, 0, 8'h00);
    chk("exec_reset", 8'h01, 8'(n_ex - e0));
    wrap_up;
  end
endmodule
